// ===== shared/mmvd_pkg.sv
// constants for the memory map and vector decoder
// assumes a 16-bit cpu address bus and 8-bit register data
package mmvd_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PORT_W = 8;

    // populated regions
    localparam logic [15:0] REG_FIRST = 16'h0000;
    localparam logic [15:0] REG_LAST = 16'h007f;
    localparam logic [15:0] RAM_FIRST = 16'h0080;
    localparam logic [15:0] RAM_LAST = 16'h017f;
    localparam logic [15:0] STACK_FIRST = 16'h0140;
    localparam logic [15:0] STACK_LAST = 16'h017f;
    localparam logic [15:0] PROG_FIRST = 16'he000;
    localparam logic [15:0] PROG_LAST = 16'hffff;
    localparam logic [15:0] VEC_FIRST = 16'hffe0;

    // port register offsets
    localparam logic [15:0] OFS_PA_VALUE = 16'h0000;
    localparam logic [15:0] OFS_PA_DIR = 16'h0001;
    localparam logic [15:0] OFS_PA_OPTION = 16'h0002;
    localparam logic [15:0] OFS_GAP = 16'h0003;
    localparam logic [15:0] OFS_PB_VALUE = 16'h0004;
    localparam logic [15:0] OFS_PB_DIR = 16'h0005;
    localparam logic [15:0] OFS_PB_OPTION = 16'h0006;
    localparam logic [15:0] OFS_RSVD_FIRST = 16'h0007;
    localparam logic [15:0] OFS_RSVD_LAST = 16'h001f;

    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] RSVD_READ = 8'h00;
    localparam logic [7:0] IDLE_READ = 8'h00;

    // two-byte vector slots, high byte at the even address
    localparam logic [15:0] VEC_TIMER_B = 16'hffea;
    localparam logic [15:0] VEC_TIMER_A = 16'hffec;
    localparam logic [15:0] VEC_SERIAL = 16'hffee;
    localparam logic [15:0] VEC_MC_EO = 16'hfff0;
    localparam logic [15:0] VEC_MC_CD = 16'hfff2;
    localparam logic [15:0] VEC_MC_RZ = 16'hfff4;
    localparam logic [15:0] VEC_EXT_B = 16'hfff6;
    localparam logic [15:0] VEC_EXT_A = 16'hfff8;
    localparam logic [15:0] VEC_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_LO_BYTE = 16'h0001;

    typedef enum logic [3:0] {
        MMVD_SRC_TIMER_B = 4'h0,
        MMVD_SRC_TIMER_A = 4'h1,
        MMVD_SRC_SERIAL = 4'h2,
        MMVD_SRC_MC_EO = 4'h3,
        MMVD_SRC_MC_CD = 4'h4,
        MMVD_SRC_MC_RZ = 4'h5,
        MMVD_SRC_EXT_B = 4'h6,
        MMVD_SRC_EXT_A = 4'h7,
        MMVD_SRC_TRAP = 4'h8,
        MMVD_SRC_RESET = 4'h9
    } mmvd_src_e;

    typedef enum logic [1:0] {
        MMVD_VEC_IDLE,
        MMVD_VEC_LOW
    } mmvd_vec_state_e;

endpackage

// ===== core/mmvd_vector_map.sv
// maps an event source to its two-byte vector slot
// assumes a source code from the fetch sequencer; purely combinational
`timescale 1ns/100ps
module mmvd_vector_map (
    input wire logic [3:0] src,
    output logic [15:0] vec_addr,
    output logic vec_ok
);
    import mmvd_pkg::*;

    always_comb begin
        vec_ok = 1'b1;
        vec_addr = VEC_RESET;
        case (src)
            MMVD_SRC_TIMER_B: vec_addr = VEC_TIMER_B;
            MMVD_SRC_TIMER_A: vec_addr = VEC_TIMER_A;
            MMVD_SRC_SERIAL: vec_addr = VEC_SERIAL;
            MMVD_SRC_MC_EO: vec_addr = VEC_MC_EO;
            MMVD_SRC_MC_CD: vec_addr = VEC_MC_CD;
            MMVD_SRC_MC_RZ: vec_addr = VEC_MC_RZ;
            MMVD_SRC_EXT_B: vec_addr = VEC_EXT_B;
            MMVD_SRC_EXT_A: vec_addr = VEC_EXT_A;
            MMVD_SRC_TRAP: vec_addr = VEC_TRAP;
            MMVD_SRC_RESET: vec_addr = VEC_RESET;
            default: begin
                vec_ok = 1'b0;
                vec_addr = VEC_RESET;
            end
        endcase
    end

endmodule

// ===== core/mmvd_top.sv
// address decoder, port registers and vector fetch sequencer
// assumes the cpu core drives the register port and vector requests
// synchronously on clk; pins are synchronous inputs
//
// Behaviour
// - decode full 16-bit, 64k byte space
// - register, ram, program regions; rest unmapped
// - stack window 0140h to 017fh inside ram
// - top addresses hold two-byte vectors
// - timer b, timer a, serial vector slots
// - three motor control vector slots
// - port b and port a external slots
// - trap slot; reset exit fetches reset vector
// - port a value, direction, option registers
// - port b value, direction, option registers
// - all port registers reset to zero
// - offset 0003h reserved, nothing behind
// - offsets 0007h to 001fh reserved
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module mmvd_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic sel_reg_area,
    output logic sel_ram,
    output logic sel_stack,
    output logic sel_program,
    output logic sel_vector,
    output logic sel_none,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_a_option_out,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    output logic [7:0] port_b_option_out,
    input wire logic vec_req,
    input wire logic [3:0] vec_src,
    output logic vec_busy,
    output logic vec_fetch_valid,
    output logic [15:0] vec_fetch_addr,
    output logic vec_fetch_last,
    output logic vec_src_err
);
    import mmvd_pkg::*;

    logic [7:0] port_a_pin_value_reg;
    logic [7:0] port_a_direction_reg;
    logic [7:0] port_a_option_reg;
    logic [7:0] port_b_pin_value_reg;
    logic [7:0] port_b_direction_reg;
    logic [7:0] port_b_option_reg;

    logic [7:0] reg_rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] port_a_read;
    logic [7:0] port_b_read;

    logic hit_reg_area;
    logic hit_ram;
    logic hit_stack;
    logic hit_program;
    logic hit_vector;
    logic hit_none;
    logic hit_rsvd;
    logic sel_reg_area_reg;
    logic sel_ram_reg;
    logic sel_stack_reg;
    logic sel_program_reg;
    logic sel_vector_reg;
    logic sel_none_reg;

    mmvd_vec_state_e vec_state_reg;
    logic boot_pend_reg;
    logic [15:0] vec_base_reg;
    logic vec_busy_reg;
    logic vec_fetch_valid_reg;
    logic [15:0] vec_fetch_addr_reg;
    logic vec_fetch_last_reg;
    logic vec_src_err_reg;
    logic [3:0] map_src;
    logic [15:0] map_addr;
    logic map_ok;
    logic vec_take;

    // region decode of the bus address
    always_comb begin
        hit_reg_area = (reg_addr >= REG_FIRST) && (reg_addr <= REG_LAST);
        hit_ram = (reg_addr >= RAM_FIRST) && (reg_addr <= RAM_LAST);
        hit_program = (reg_addr >= PROG_FIRST) && (reg_addr <= PROG_LAST);
        hit_stack = (reg_addr >= STACK_FIRST) && (reg_addr <= STACK_LAST);
        hit_vector = (reg_addr >= VEC_FIRST) && (reg_addr <= PROG_LAST);
        hit_none = !(hit_reg_area || hit_ram || hit_program);
    end

    // reserved register offsets
    always_comb begin
        hit_rsvd = (reg_addr == OFS_GAP) ||
                   ((reg_addr >= OFS_RSVD_FIRST) &&
                    (reg_addr <= OFS_RSVD_LAST));
    end

    // region flags follow each strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_reg_area_reg <= 1'b0;
            sel_ram_reg <= 1'b0;
            sel_stack_reg <= 1'b0;
            sel_program_reg <= 1'b0;
            sel_vector_reg <= 1'b0;
            sel_none_reg <= 1'b0;
        end else if (reg_wr || reg_rd) begin
            sel_reg_area_reg <= hit_reg_area;
            sel_ram_reg <= hit_ram;
            sel_stack_reg <= hit_stack;
            sel_program_reg <= hit_program;
            sel_vector_reg <= hit_vector;
            sel_none_reg <= hit_none;
        end else begin
            sel_reg_area_reg <= 1'b0;
            sel_ram_reg <= 1'b0;
            sel_stack_reg <= 1'b0;
            sel_program_reg <= 1'b0;
            sel_vector_reg <= 1'b0;
            sel_none_reg <= 1'b0;
        end
    end

    // port a registers
    always_ff @(posedge clk) begin
        if (srst) begin
            port_a_pin_value_reg <= PORT_RESET;
            port_a_direction_reg <= PORT_RESET;
            port_a_option_reg <= PORT_RESET;
        end else if (reg_wr) begin
            if (reg_addr == OFS_PA_VALUE) begin
                port_a_pin_value_reg <= reg_wdata;
            end
            if (reg_addr == OFS_PA_DIR) begin
                port_a_direction_reg <= reg_wdata;
            end
            if (reg_addr == OFS_PA_OPTION) begin
                port_a_option_reg <= reg_wdata;
            end
        end
    end

    // port b registers
    always_ff @(posedge clk) begin
        if (srst) begin
            port_b_pin_value_reg <= PORT_RESET;
            port_b_direction_reg <= PORT_RESET;
            port_b_option_reg <= PORT_RESET;
        end else if (reg_wr) begin
            if (reg_addr == OFS_PB_VALUE) begin
                port_b_pin_value_reg <= reg_wdata;
            end
            if (reg_addr == OFS_PB_DIR) begin
                port_b_direction_reg <= reg_wdata;
            end
            if (reg_addr == OFS_PB_OPTION) begin
                port_b_option_reg <= reg_wdata;
            end
        end
    end

    // value read: output bits from the latch, input bits from the pin
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_pin_read
            assign port_a_read[gi] = port_a_direction_reg[gi] ?
                port_a_pin_value_reg[gi] : port_a_in[gi];
            assign port_b_read[gi] = port_b_direction_reg[gi] ?
                port_b_pin_value_reg[gi] : port_b_in[gi];
        end
    endgenerate

    // read multiplexer
    always_comb begin
        rdata_next = IDLE_READ;
        if (reg_rd) begin
            case (reg_addr)
                OFS_PA_VALUE: rdata_next = port_a_read;
                OFS_PA_DIR: rdata_next = port_a_direction_reg;
                OFS_PA_OPTION: rdata_next = port_a_option_reg;
                OFS_PB_VALUE: rdata_next = port_b_read;
                OFS_PB_DIR: rdata_next = port_b_direction_reg;
                OFS_PB_OPTION: rdata_next = port_b_option_reg;
                default: begin
                    if (hit_rsvd) begin
                        rdata_next = RSVD_READ;
                    end else begin
                        rdata_next = IDLE_READ;
                    end
                end
            endcase
        end
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata_reg <= IDLE_READ;
        end else begin
            reg_rdata_reg <= rdata_next;
        end
    end

    // vector request source, reset exit first
    always_comb begin
        if (boot_pend_reg) begin
            map_src = MMVD_SRC_RESET;
        end else begin
            map_src = vec_src;
        end
        vec_take = (vec_state_reg == MMVD_VEC_IDLE) &&
                   (boot_pend_reg || vec_req);
    end

    mmvd_vector_map u_map (
        .src(map_src),
        .vec_addr(map_addr),
        .vec_ok(map_ok)
    );

    // two-cycle vector fetch: high byte then low byte
    always_ff @(posedge clk) begin
        if (srst) begin
            vec_state_reg <= MMVD_VEC_IDLE;
            boot_pend_reg <= 1'b1;
            vec_base_reg <= VEC_RESET;
            vec_busy_reg <= 1'b0;
            vec_fetch_valid_reg <= 1'b0;
            vec_fetch_addr_reg <= VEC_RESET;
            vec_fetch_last_reg <= 1'b0;
            vec_src_err_reg <= 1'b0;
        end else begin
            vec_fetch_valid_reg <= 1'b0;
            vec_fetch_last_reg <= 1'b0;
            vec_src_err_reg <= 1'b0;
            case (vec_state_reg)
                MMVD_VEC_IDLE: begin
                    if (vec_take) begin
                        boot_pend_reg <= 1'b0;
                        if (map_ok) begin
                            vec_base_reg <= map_addr;
                            vec_fetch_addr_reg <= map_addr;
                            vec_fetch_valid_reg <= 1'b1;
                            vec_busy_reg <= 1'b1;
                            vec_state_reg <= MMVD_VEC_LOW;
                        end else begin
                            vec_src_err_reg <= 1'b1;
                        end
                    end
                end
                MMVD_VEC_LOW: begin
                    vec_fetch_addr_reg <= vec_base_reg | VEC_LO_BYTE;
                    vec_fetch_valid_reg <= 1'b1;
                    vec_fetch_last_reg <= 1'b1;
                    vec_busy_reg <= 1'b0;
                    vec_state_reg <= MMVD_VEC_IDLE;
                end
                default: begin
                    vec_busy_reg <= 1'b0;
                    vec_state_reg <= MMVD_VEC_IDLE;
                end
            endcase
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = reg_rdata_reg;
    assign sel_reg_area = sel_reg_area_reg;
    assign sel_ram = sel_ram_reg;
    assign sel_stack = sel_stack_reg;
    assign sel_program = sel_program_reg;
    assign sel_vector = sel_vector_reg;
    assign sel_none = sel_none_reg;
    assign port_a_out = port_a_pin_value_reg;
    assign port_a_oe = port_a_direction_reg;
    assign port_a_option_out = port_a_option_reg;
    assign port_b_out = port_b_pin_value_reg;
    assign port_b_oe = port_b_direction_reg;
    assign port_b_option_out = port_b_option_reg;
    assign vec_busy = vec_busy_reg;
    assign vec_fetch_valid = vec_fetch_valid_reg;
    assign vec_fetch_addr = vec_fetch_addr_reg;
    assign vec_fetch_last = vec_fetch_last_reg;
    assign vec_src_err = vec_src_err_reg;

endmodule

// ===== tb/mmvd_chk.sv
// checker for decode flags, port registers and vector fetch
// assumes it is bound onto mmvd_top; one clock, synchronous reset
`timescale 1ns/100ps
module mmvd_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sel_reg_area,
    input wire logic sel_ram,
    input wire logic sel_stack,
    input wire logic sel_program,
    input wire logic sel_vector,
    input wire logic sel_none,
    input wire logic [7:0] port_a_option_out,
    input wire logic [7:0] port_b_oe,
    input wire logic vec_req,
    input wire logic [3:0] vec_src,
    input wire logic vec_busy,
    input wire logic vec_fetch_valid,
    input wire logic [15:0] vec_fetch_addr,
    input wire logic vec_fetch_last,
    input wire logic vec_src_err
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    logic stb;
    assign stb = reg_wr | reg_rd;
    sequence s_hi;
        vec_fetch_valid && !vec_fetch_last && !vec_fetch_addr[0];
    endsequence
    sequence s_lo;
        vec_fetch_valid && vec_fetch_last && vec_fetch_addr[0];
    endsequence
    a_full_decode:
    assert property (stb && reg_addr[15:7] != 9'h000 |=> !sel_reg_area)
    else $error("register area flagged above 007f");
    a_unmapped_none:
    assert property (stb && reg_addr >= 16'h0180 && reg_addr <= 16'hdfff
        |=> sel_none && !sel_ram && !sel_program)
    else $error("unmapped address not flagged");
    a_stack_window:
    assert property (stb && reg_addr >= 16'h0140 && reg_addr <= 16'h017f
        |=> sel_stack && sel_ram)
    else $error("stack window not flagged");
    a_vector_area:
    assert property (stb && reg_addr >= 16'hffe0 |=> sel_vector && sel_program)
    else $error("vector area not flagged");
    a_byte_pair:
    assert property (s_hi |=> s_lo ##0
        vec_fetch_addr == $past(vec_fetch_addr) + 16'h0001)
    else $error("vector low byte not after high byte");
    a_serial_slot:
    assert property (vec_req && !vec_busy && vec_src == 4'h2
        |=> s_hi ##0 vec_fetch_addr == 16'hffee)
    else $error("serial vector slot wrong");
    a_reset_fetch:
    assert property ($fell(srst) |=> s_hi ##0 vec_fetch_addr == 16'hfffe
        ##1 s_lo)
    else $error("reset vector not fetched");
    a_reg_area:
    assert property (stb && reg_addr <= 16'h007f
        |=> sel_reg_area && !sel_none)
    else $error("register area not flagged");
    a_unused_slot:
    assert property (vec_fetch_valid |-> vec_fetch_addr >= 16'hffea
        && vec_fetch_addr[15:1] != 15'h7ffd)
    else $error("unassigned vector slot fetched");
    a_bad_source:
    assert property (vec_req && !vec_busy && vec_src > 4'h9
        |=> vec_src_err && !vec_fetch_valid)
    else $error("bad source code not refused");
    a_reserved_read:
    assert property (reg_rd && (reg_addr == 16'h0003 ||
        (reg_addr >= 16'h0007 && reg_addr <= 16'h001f)) |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
    a_option_write:
    assert property (reg_wr && reg_addr == 16'h0002
        |=> port_a_option_out == $past(reg_wdata))
    else $error("port a option write lost");
    a_dir_write:
    assert property (reg_wr && reg_addr == 16'h0005
        |=> port_b_oe == $past(reg_wdata))
    else $error("port b direction write lost");
endmodule
bind mmvd_top mmvd_chk mmvd_chk_inst (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sel_reg_area(sel_reg_area),
    .sel_ram(sel_ram), .sel_stack(sel_stack), .sel_program(sel_program),
    .sel_vector(sel_vector), .sel_none(sel_none),
    .port_a_option_out(port_a_option_out), .port_b_oe(port_b_oe),
    .vec_req(vec_req), .vec_src(vec_src), .vec_busy(vec_busy),
    .vec_fetch_valid(vec_fetch_valid), .vec_fetch_addr(vec_fetch_addr),
    .vec_fetch_last(vec_fetch_last), .vec_src_err(vec_src_err));

// ===== tb/mmvd_cpu_model.sv
// cpu core model: register port cycles and vector requests
// assumes the decoder takes strobes on the rising edge of clk
`timescale 1ns/100ps
module mmvd_cpu_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [15:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic vec_req,
    output logic [3:0] vec_src
);
    initial begin
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        vec_req = 1'b0;
        vec_src = 4'h0;
    end
    // released lines show the inverse of the last value
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
    task automatic req(input logic [3:0] s);
        @(posedge clk);
        vec_req <= 1'b1;
        vec_src <= s;
        @(posedge clk);
        vec_req <= 1'b0;
        vec_src <= ~s;
    endtask
    // request held over the busy cycle with a new code
    task automatic req_held(input logic [3:0] s0, input logic [3:0] s1);
        @(posedge clk);
        vec_req <= 1'b1;
        vec_src <= s0;
        @(posedge clk);
        vec_src <= s1;
        @(posedge clk);
        vec_req <= 1'b0;
        vec_src <= ~s1;
    endtask
endmodule

// ===== tb/mmvd_top_tb.sv
// testbench for mmvd_top with the cpu model on its register port
// assumes a 25 mhz clock and reset held for 16 cycles
`timescale 1ns/100ps
module mmvd_top_tb;
    import mmvd_pkg::*;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
    typedef struct packed {logic [1:0] op; logic [15:0] a; logic [7:0] d;}
        mmvd_row_s;
    logic clk, srst = 1'b1;
    logic [15:0] reg_addr, vec_fetch_addr;
    logic [7:0] reg_wdata, reg_rdata, rdv;
    logic [7:0] port_a_in = 8'h5a, port_b_in = 8'h90;
    logic [7:0] pa_out, pa_oe, pa_opt, pb_out, pb_oe, pb_opt;
    logic reg_wr, reg_rd, vec_req, vec_busy, vec_valid, vec_last, vec_err;
    logic [3:0] vec_src;
    wire [5:0] sel;
    wire [18:0] vq = {vec_valid, vec_last, vec_busy, vec_fetch_addr};
    wire [47:0] pouts = {pa_out, pa_oe, pa_opt, pb_out, pb_oe, pb_opt};
    int n_errors = 0, n_compared = 0;
    mmvd_row_s rows [21] = '{'{2'h0, 16'h0001, 8'hff},
        '{2'h0, 16'h0000, 8'ha5}, '{2'h1, 16'h0000, 8'ha5},
        '{2'h0, 16'h0002, 8'h3c}, '{2'h1, 16'h0002, 8'h3c},
        '{2'h0, 16'h0005, 8'h0f}, '{2'h0, 16'h0004, 8'h77},
        '{2'h1, 16'h0004, 8'h97}, '{2'h0, 16'h0006, 8'hc3},
        '{2'h1, 16'h0006, 8'hc3}, '{2'h0, 16'h0003, 8'h55},
        '{2'h1, 16'h0003, 8'h00}, '{2'h0, 16'h0010, 8'hee},
        '{2'h1, 16'h0010, 8'h00}, '{2'h1, 16'h001f, 8'h00},
        '{2'h0, 16'h0001, 8'h0f}, '{2'h1, 16'h0000, 8'h55},
        '{2'h1, 16'h1002, 8'h00}, '{2'h2, 16'h0150, 8'h18},
        '{2'h2, 16'hfffa, 8'h06}, '{2'h2, 16'he000, 8'h04}};
    logic [15:0] vexp [10] = '{16'hffea, 16'hffec, 16'hffee, 16'hfff0,
        16'hfff2, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffc, 16'hfffe};
    mmvd_cpu_model mmvd_cpu_model_inst (.clk(clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .vec_req(vec_req), .vec_src(vec_src));
    mmvd_top mmvd_top_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sel_reg_area(sel[5]), .sel_ram(sel[4]),
        .sel_stack(sel[3]), .sel_program(sel[2]), .sel_vector(sel[1]),
        .sel_none(sel[0]), .port_a_in(port_a_in),
        .port_a_out(pa_out), .port_a_oe(pa_oe), .port_a_option_out(pa_opt),
        .port_b_in(port_b_in), .port_b_out(pb_out), .port_b_oe(pb_oe),
        .port_b_option_out(pb_opt), .vec_req(vec_req), .vec_src(vec_src),
        .vec_busy(vec_busy), .vec_fetch_valid(vec_valid),
        .vec_fetch_addr(vec_fetch_addr), .vec_fetch_last(vec_last),
        .vec_src_err(vec_err));
    task automatic finish_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // value registers read the pins while direction is zero
    task automatic zero_chk();
        logic [7:0] ex;
        `CHK("port_outs", 48'h0, pouts)
        for (int i = 0; i < 6; i++) begin
            ex = (i == 0) ? port_a_in : (i == 3) ? port_b_in : 8'h00;
            mmvd_cpu_model_inst.rd(16'(i + i / 3), rdv);
            `CHK("reset_read", ex, rdv)
        end
    endtask
    task automatic vchk(input logic [3:0] s, input logic [15:0] e);
        mmvd_cpu_model_inst.req(s);
        #1;
        `CHK("vec_hi", {3'b101, e}, vq)
        @(posedge clk);
        #1;
        `CHK("vec_lo", {3'b110, e + 16'h0001}, vq)
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        zero_chk();
        foreach (rows[i]) begin
            if (rows[i].op == 2'h0) begin
                mmvd_cpu_model_inst.wr(rows[i].a, rows[i].d);
            end else begin
                mmvd_cpu_model_inst.rd(rows[i].a, rdv);
                if (rows[i].op == 2'h1) begin
                    `CHK("rdata", rows[i].d, rdv)
                end else begin
                    `CHK("sel", rows[i].d[5:0], sel)
                end
            end
        end
        @(posedge clk);
        #1;
        `CHK("strobe_end", 14'h0, {sel, reg_rdata})
        `CHK("port_regs", 32'ha50f77c3, {pa_out, pa_oe, pb_out, pb_opt})
        for (int s = 0; s < 10; s++) vchk(4'(s), vexp[s]);
        for (int s = 10; s < 16; s++) begin
            mmvd_cpu_model_inst.req(4'(s));
            #1;
            `CHK("src_err", 2'b10, {vec_err, vec_valid})
        end
        mmvd_cpu_model_inst.req_held(4'h0, 4'h1);
        #1;
        `CHK("busy_drop", 19'h6ffeb, vq)
        @(posedge clk);
        #1;
        `CHK("drop_idle", 2'b00, {vec_valid, vec_err})
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        zero_chk();
        finish_test();
    end
endmodule
